// >>> include/hb_pkg.sv
// Constants, types and decode helpers for the H-bridge gate drive control block
package hb_pkg;
	localparam int CLK_NS = 40;
	localparam int DEAD_NS = 150;
	localparam int DEGLITCH_NS = 200;
	localparam int DRIVE_NS = 2000;
	localparam int OCP_NS = 2000;
	localparam int BLANK_NS = 1800;
	localparam int TOFF_NS = 25000;
	localparam int RETRY_US = 4000;
	localparam int CNT_W = 10;
	localparam int RETRY_W = 17;
	// Dead time is a least time, so it rounds up
	localparam logic [CNT_W-1:0] DEAD_CYC = CNT_W'((DEAD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] DEGLITCH_CYC = CNT_W'((DEGLITCH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] DRIVE_CYC = CNT_W'((DRIVE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] OCP_CYC = CNT_W'((OCP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] BLANK_CYC = CNT_W'((BLANK_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] TOFF_CYC = CNT_W'((TOFF_NS + CLK_NS - 1) / CLK_NS);
	localparam int RETRY_CYC_DEFAULT = (RETRY_US * 1000) / CLK_NS;
	// Gate currents in units of 0.1 mA
	localparam logic [11:0] I_6MA = 12'h003C;
	localparam logic [11:0] I_12MA5 = 12'h007D;
	localparam logic [11:0] I_25MA = 12'h00FA;
	localparam logic [11:0] I_50MA = 12'h01F4;
	localparam logic [11:0] I_100MA = 12'h03E8;
	localparam logic [11:0] I_150MA = 12'h05DC;
	localparam logic [11:0] I_200MA = 12'h07D0;
	localparam logic [11:0] I_300MA = 12'h0BB8;

	typedef enum logic [1:0] {
		HALF_OFF = 2'b00,
		HALF_HIGH = 2'b01,
		HALF_LOW = 2'b10,
		HALF_DEAD = 2'b11
	} half_state_t;

	typedef enum logic [1:0] {
		CMD_COAST = 2'b00,
		CMD_REVERSE = 2'b01,
		CMD_FORWARD = 2'b10,
		CMD_BRAKE = 2'b11
	} bridge_cmd_t;

	// Level seen on the drive-strength pin, lowest to highest
	typedef enum logic [2:0] {
		LVL_GND = 3'b000,
		LVL_0V7 = 3'b001,
		LVL_2V = 3'b010,
		LVL_OPEN = 3'b011,
		LVL_4V = 3'b100,
		LVL_AREG = 3'b101
	} drive_level_t;

	typedef struct packed {
		logic [11:0] src;
		logic [11:0] snk;
		logic hs_ocp_en;
	} drive_setting_t;

	typedef struct packed {
		logic high_on;
		logic low_on;
		logic peak;
		logic low_strong;
	} half_drive_t;

	typedef struct packed {
		logic out;
		logic oe;
	} od_pin_t;

	function automatic drive_setting_t decode_drive(input logic [2:0] lvl);
		drive_setting_t s;
		s = '{src: I_100MA, snk: I_200MA, hs_ocp_en: 1'b1};
		unique case (lvl)
			LVL_GND: s = '{src: I_6MA, snk: I_12MA5, hs_ocp_en: 1'b1};
			LVL_0V7: s = '{src: I_12MA5, snk: I_25MA, hs_ocp_en: 1'b1};
			LVL_2V: s = '{src: I_25MA, snk: I_50MA, hs_ocp_en: 1'b1};
			LVL_OPEN: s = '{src: I_100MA, snk: I_200MA, hs_ocp_en: 1'b1};
			LVL_4V: s = '{src: I_150MA, snk: I_300MA, hs_ocp_en: 1'b1};
			LVL_AREG: s = '{src: I_25MA, snk: I_50MA, hs_ocp_en: 1'b0};
			// Unused level codes fall back to the floating-pin setting
			default: s = '{src: I_100MA, snk: I_200MA, hs_ocp_en: 1'b1};
		endcase
		return s;
	endfunction : decode_drive
endpackage : hb_pkg

// >>> logic/hbridge_gate_drive_control.sv
// H-bridge gate drive sequencing, current chopping, overcurrent retry and regulator enables
`timescale 1ns/1ps

module hbridge_gate_drive_control #(
	parameter int unsigned RETRY_CYCLES = hb_pkg::RETRY_CYC_DEFAULT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Controller inputs
	input wire logic sleep_n,
	input wire logic [1:0] bridge_inputs,
	input wire logic [2:0] drive_strength_select,
	input wire logic current_limit_enable,
	// Analog monitors
	input wire logic chop_threshold,
	input wire logic [3:0] drain_source_trip_level,
	input wire logic thermal_shutdown,
	input wire logic supply_undervoltage_lockout,
	// Gate drive
	output hb_pkg::half_drive_t [1:0] gate_drive,
	output hb_pkg::drive_setting_t drive_setting,
	// Indicators
	output hb_pkg::od_pin_t chop_indicator_n,
	output hb_pkg::od_pin_t fault_n,
	// Regulator enables
	output logic analog_regulator_out_en,
	output logic digital_regulator_out_en
);
	localparam int RW = hb_pkg::RETRY_W;
	localparam int CW = hb_pkg::CNT_W;

	logic [1:0] in_filt;
	hb_pkg::bridge_cmd_t cmd;
	logic bridge_off;
	hb_pkg::half_state_t target [2];
	logic chop_active, next_chop_active;
	logic [CW-1:0] toff_cnt, next_toff_cnt, blank_cnt, next_blank_cnt;
	logic ocp_fault, next_ocp_fault;
	logic [CW-1:0] ocp_cnt, next_ocp_cnt;
	logic [RW-1:0] retry_cnt, next_retry_cnt;
	logic any_trip;
	logic captured, next_captured;
	hb_pkg::drive_setting_t next_drive_setting;
	hb_pkg::od_pin_t next_chop_ind, next_fault_n;
	logic next_analog_en, next_digital_en;

	// Input deglitch: a new level must persist for the full window
	for (genvar g = 0; g < 2; g++) begin : dg
		logic filt, next_filt;
		logic [CW-1:0] cnt, next_cnt;
		always_comb begin
			next_filt = filt;
			next_cnt = '0;
			if (bridge_inputs[g] != filt) begin
				if (cnt == hb_pkg::DEGLITCH_CYC - 1'b1) begin
					next_filt = bridge_inputs[g];
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
		end
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				filt <= 1'b0;
				cnt <= '0;
			end else begin
				filt <= next_filt;
				cnt <= next_cnt;
			end
		end
		assign in_filt[g] = filt;
	end

	// Command decode; chopping overrides drive with low-side slow decay
	always_comb begin
		cmd = hb_pkg::bridge_cmd_t'(in_filt);
		bridge_off = !sleep_n || ocp_fault || thermal_shutdown || supply_undervoltage_lockout;
		target[0] = hb_pkg::HALF_OFF;
		target[1] = hb_pkg::HALF_OFF;
		if (bridge_off) begin
			target[0] = hb_pkg::HALF_OFF;
			target[1] = hb_pkg::HALF_OFF;
		end else if (chop_active || cmd == hb_pkg::CMD_BRAKE) begin
			target[0] = hb_pkg::HALF_LOW;
			target[1] = hb_pkg::HALF_LOW;
		end else if (cmd == hb_pkg::CMD_FORWARD) begin
			target[0] = hb_pkg::HALF_HIGH;
			target[1] = hb_pkg::HALF_LOW;
		end else if (cmd == hb_pkg::CMD_REVERSE) begin
			target[0] = hb_pkg::HALF_LOW;
			target[1] = hb_pkg::HALF_HIGH;
		end
	end

	// Per half-bridge: break before make, then peak phase, then hold
	for (genvar h = 0; h < 2; h++) begin : hb
		hb_pkg::half_state_t st, next_st;
		logic [CW-1:0] dead_cnt, next_dead_cnt, peak_cnt, next_peak_cnt;
		hb_pkg::half_drive_t drv, next_drv;
		always_comb begin
			next_st = st;
			next_dead_cnt = dead_cnt;
			unique case (st)
				hb_pkg::HALF_OFF: next_st = target[h];
				hb_pkg::HALF_HIGH, hb_pkg::HALF_LOW: begin
					if (target[h] != st) begin
						next_st = hb_pkg::HALF_DEAD;
						next_dead_cnt = hb_pkg::DEAD_CYC;
					end
				end
				hb_pkg::HALF_DEAD: begin
					if (dead_cnt == 1'b1) begin
						next_st = target[h];
					end else begin
						next_dead_cnt = dead_cnt - 1'b1;
					end
				end
			endcase
			if (next_st != st) begin
				next_peak_cnt = hb_pkg::DRIVE_CYC;
			end else if (peak_cnt != '0) begin
				next_peak_cnt = peak_cnt - 1'b1;
			end else begin
				next_peak_cnt = '0;
			end
			next_drv.high_on = next_st == hb_pkg::HALF_HIGH;
			next_drv.low_on = next_st == hb_pkg::HALF_LOW;
			next_drv.peak = next_peak_cnt != '0;
			next_drv.low_strong = next_drv.high_on && next_drv.peak;
		end
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				st <= hb_pkg::HALF_OFF;
				dead_cnt <= '0;
				peak_cnt <= '0;
				drv <= '0;
			end else begin
				st <= next_st;
				dead_cnt <= next_dead_cnt;
				peak_cnt <= next_peak_cnt;
				drv <= next_drv;
			end
		end
		assign gate_drive[h] = drv;
	end

	// Chopping: blank, compare, fixed off-time, then restart drive
	always_comb begin
		next_chop_active = chop_active;
		next_toff_cnt = toff_cnt;
		next_blank_cnt = blank_cnt;
		if (bridge_off || !current_limit_enable ||
			!(cmd == hb_pkg::CMD_FORWARD || cmd == hb_pkg::CMD_REVERSE)) begin
			next_chop_active = 1'b0;
			next_toff_cnt = '0;
			next_blank_cnt = hb_pkg::BLANK_CYC;
		end else if (chop_active) begin
			if (toff_cnt == 1'b1) begin
				next_chop_active = 1'b0;
				next_blank_cnt = hb_pkg::BLANK_CYC;
			end else begin
				next_toff_cnt = toff_cnt - 1'b1;
			end
		end else if (blank_cnt != '0) begin
			next_blank_cnt = blank_cnt - 1'b1;
		end else if (chop_threshold) begin
			next_chop_active = 1'b1;
			next_toff_cnt = hb_pkg::TOFF_CYC;
		end
		next_chop_ind.out = 1'b0;
		next_chop_ind.oe = next_chop_active;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chop_active <= 1'b0;
			toff_cnt <= '0;
			blank_cnt <= hb_pkg::BLANK_CYC;
			chop_indicator_n <= '0;
		end else begin
			chop_active <= next_chop_active;
			toff_cnt <= next_toff_cnt;
			blank_cnt <= next_blank_cnt;
			chop_indicator_n <= next_chop_ind;
		end
	end

	// Drain-source monitor on conducting transistors, deglitch and retry
	always_comb begin
		any_trip = 1'b0;
		for (int h = 0; h < 2; h++) begin
			any_trip = any_trip ||
				(gate_drive[h].high_on && drive_setting.hs_ocp_en &&
				drain_source_trip_level[2*h]) ||
				(gate_drive[h].low_on && drain_source_trip_level[2*h+1]);
		end
		next_ocp_fault = ocp_fault;
		next_ocp_cnt = '0;
		next_retry_cnt = retry_cnt;
		if (ocp_fault) begin
			if (retry_cnt == 1'b1) begin
				next_ocp_fault = 1'b0;
			end else begin
				next_retry_cnt = retry_cnt - 1'b1;
			end
		end else if (any_trip) begin
			if (ocp_cnt == hb_pkg::OCP_CYC - 1'b1) begin
				next_ocp_fault = 1'b1;
				next_retry_cnt = RW'(RETRY_CYCLES);
			end else begin
				next_ocp_cnt = ocp_cnt + 1'b1;
			end
		end
		next_fault_n.out = 1'b0;
		next_fault_n.oe = next_ocp_fault || thermal_shutdown || supply_undervoltage_lockout;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ocp_fault <= 1'b0;
			ocp_cnt <= '0;
			retry_cnt <= '0;
			fault_n <= '0;
		end else begin
			ocp_fault <= next_ocp_fault;
			ocp_cnt <= next_ocp_cnt;
			retry_cnt <= next_retry_cnt;
			fault_n <= next_fault_n;
		end
	end

	// Drive setting is caught once after reset so it cannot move mid-operation
	always_comb begin
		next_captured = 1'b1;
		next_drive_setting = drive_setting;
		if (!captured) begin
			next_drive_setting = hb_pkg::decode_drive(drive_strength_select);
		end
		next_digital_en = sleep_n;
		next_analog_en = sleep_n && !thermal_shutdown && !supply_undervoltage_lockout;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			captured <= 1'b0;
			drive_setting <= '{src: hb_pkg::I_100MA, snk: hb_pkg::I_200MA, hs_ocp_en: 1'b1};
			analog_regulator_out_en <= 1'b0;
			digital_regulator_out_en <= 1'b0;
		end else begin
			captured <= next_captured;
			drive_setting <= next_drive_setting;
			analog_regulator_out_en <= next_analog_en;
			digital_regulator_out_en <= next_digital_en;
		end
	end

	a_ind_reg_off: assert property (@(posedge clk) disable iff (!nrst)
		!$past(current_limit_enable) |-> !chop_indicator_n.oe)
		else $error("chop indicator active with regulation disabled");
	a_ind_no_brake: assert property (@(posedge clk) disable iff (!nrst)
		$past(cmd) == hb_pkg::CMD_BRAKE |-> !chop_indicator_n.oe)
		else $error("chop indicator active on commanded brake");
	a_ind_decay: assert property (@(posedge clk) disable iff (!nrst)
		chop_indicator_n.oe |-> gate_drive[0].low_on || gate_drive[1].low_on ||
		!gate_drive[0].high_on && !gate_drive[1].high_on)
		else $error("chop indicator active while a high side conducts");
	a_no_shoot: assert property (@(posedge clk) disable iff (!nrst)
		!(gate_drive[0].high_on && gate_drive[0].low_on) &&
		!(gate_drive[1].high_on && gate_drive[1].low_on))
		else $error("both transistors of a half-bridge on");
	a_dead_gap: assert property (@(posedge clk) disable iff (!nrst)
		$fell(gate_drive[0].high_on) |-> !gate_drive[0].low_on [*4])
		else $error("dead time too short");
	a_peak_start: assert property (@(posedge clk) disable iff (!nrst)
		$rose(gate_drive[1].high_on) |-> gate_drive[1].peak)
		else $error("no peak phase on turn-on");
	a_peak_end: assert property (@(posedge clk) disable iff (!nrst)
		$fell(gate_drive[0].peak) && gate_drive[0].high_on |-> $past(gate_drive[0].high_on, 50))
		else $error("peak phase ended early");
	a_strong_pull: assert property (@(posedge clk) disable iff (!nrst)
		$rose(gate_drive[0].high_on) |-> gate_drive[0].low_strong && !gate_drive[0].low_on)
		else $error("no strong pull-down during high turn-on");
	a_deglitch_in: assert property (@(posedge clk) disable iff (!nrst)
		$changed(in_filt[0]) |-> $past(bridge_inputs[0], 5) == in_filt[0])
		else $error("input passed deglitch too early");
	a_ocp_off: assert property (@(posedge clk) disable iff (!nrst)
		$rose(ocp_fault) |=> !gate_drive[0].high_on && !gate_drive[0].low_on &&
		!gate_drive[1].high_on && !gate_drive[1].low_on && fault_n.oe)
		else $error("bridge not disabled on overcurrent");
	a_sleep_regs: assert property (@(posedge clk) disable iff (!nrst)
		!sleep_n |=> !analog_regulator_out_en && !digital_regulator_out_en)
		else $error("regulators enabled in sleep");
	a_fault_areg: assert property (@(posedge clk) disable iff (!nrst)
		thermal_shutdown || supply_undervoltage_lockout |=> !analog_regulator_out_en)
		else $error("analog regulator on during fault");
endmodule : hbridge_gate_drive_control

// >>> verification/motor_model.sv
// Winding, sense comparator, drain-source monitors and pull-ups seen by the bridge
`timescale 1ns/1ps
module motor_model (
	// Clock
	input wire logic clk,
	// Bridge side
	input hb_pkg::half_drive_t [1:0] gate_drive,
	input hb_pkg::od_pin_t chop_indicator_n,
	input hb_pkg::od_pin_t fault_n,
	// Scenario controls
	input wire logic force_chop,
	input wire logic [3:0] trip_mask,
	// Monitor outputs
	output logic chop_threshold,
	output logic [3:0] drain_source_trip_level,
	output logic chop_line,
	output logic fault_line
);
	int rise;
	logic [3:0] on;
	always_ff @(posedge clk) begin
		rise <= (gate_drive[0].high_on | gate_drive[1].high_on) ? rise + 1 : 0;
	end
	assign on = {gate_drive[1].low_on, gate_drive[1].high_on, gate_drive[0].low_on,
		gate_drive[0].high_on};
	// Winding current crosses the chop level a while after drive starts
	assign chop_threshold = force_chop | (rise > 200);
	// A trip only shows while that FET conducts, so an off bridge clears it
	assign drain_source_trip_level = trip_mask & on;
	// Pull-ups on both open-drain lines
	assign chop_line = chop_indicator_n.oe ? chop_indicator_n.out : 1'h1;
	assign fault_line = fault_n.oe ? fault_n.out : 1'h1;
endmodule : motor_model

// >>> verification/testbench.sv
// Self-checking bench for the H-bridge gate drive control block
`timescale 1ns/1ps
module testbench;
	logic clk;
	logic nrst = 0;
	logic sleep_n = 1;
	logic [1:0] bridge_inputs = 2'h3;
	logic [2:0] drive_strength_select = 3'h3;
	logic current_limit_enable = 1;
	logic thermal_shutdown = 0;
	logic supply_undervoltage_lockout = 0;
	logic force_chop = 0;
	logic [3:0] trip_mask = 4'h0;
	logic chop_threshold, chop_line, fault_line;
	logic analog_regulator_out_en, digital_regulator_out_en;
	logic [3:0] drain_source_trip_level;
	hb_pkg::half_drive_t [1:0] gate_drive;
	hb_pkg::drive_setting_t drive_setting;
	hb_pkg::od_pin_t chop_indicator_n, fault_n;
	typedef struct {string n; int c; logic [24:0] e;} note_t;
	note_t q[$];
	note_t nt;
	logic [24:0] seen, meas;
	logic [2:0] mon;
	logic [7:0] cmd_gate [4] = '{8'h00, 8'h84, 8'h48, 8'h44};
	int run[3], last[3];
	int num_errors = 0;
	int n_tests = 0;
	int k, j;

	hbridge_gate_drive_control #(.RETRY_CYCLES(20)) i_hbridge_gate_drive_control (
		.clk(clk), .nrst(nrst), .sleep_n(sleep_n), .bridge_inputs(bridge_inputs),
		.drive_strength_select(drive_strength_select),
		.current_limit_enable(current_limit_enable), .chop_threshold(chop_threshold),
		.drain_source_trip_level(drain_source_trip_level),
		.thermal_shutdown(thermal_shutdown),
		.supply_undervoltage_lockout(supply_undervoltage_lockout),
		.gate_drive(gate_drive), .drive_setting(drive_setting),
		.chop_indicator_n(chop_indicator_n), .fault_n(fault_n),
		.analog_regulator_out_en(analog_regulator_out_en),
		.digital_regulator_out_en(digital_regulator_out_en));
	motor_model i_motor_model (.clk(clk), .gate_drive(gate_drive),
		.chop_indicator_n(chop_indicator_n), .fault_n(fault_n), .force_chop(force_chop),
		.trip_mask(trip_mask), .chop_threshold(chop_threshold),
		.drain_source_trip_level(drain_source_trip_level), .chop_line(chop_line),
		.fault_line(fault_line));

	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end

	// Lengths of the last completed runs of peak, chop and fault
	assign mon = {~fault_line, ~chop_line, gate_drive[0].peak};
	always @(negedge clk) begin
		for (int i = 0; i < 3; i++) begin
			if (mon[i] === 1'h1) begin
				run[i]++;
			end else begin
				if (run[i] != 0) last[i] = run[i];
				run[i] = 0;
			end
		end
	end

	task automatic check(string n, logic [24:0] s, logic [24:0] e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask : check

	// Notes are judged at the next falling edge, once outputs have settled
	always @(negedge clk) begin
		while (q.size() > 0) begin
			nt = q.pop_front();
			case (nt.c)
				0: seen = 25'(gate_drive);
				1: seen = drive_setting;
				2: seen = {23'h0, chop_line, fault_line};
				3: seen = {23'h0, analog_regulator_out_en, digital_regulator_out_en};
				// Conduction bits only; peak also runs while a gate is being discharged
				5: seen = 25'(gate_drive) & 25'h0cc;
				default: seen = meas;
			endcase
			check(nt.n, seen, nt.e);
		end
	end

	task automatic note(string n, int c, logic [24:0] e);
		q.push_back('{n, c, e});
	endtask : note

	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic put(string n, logic [24:0] v, logic [24:0] e);
		@(posedge clk);
		meas = v;
		note(n, 4, e);
		@(posedge clk);
	endtask : put

	function automatic logic [24:0] exp_set(int l);
		case (l)
			0: return {hb_pkg::I_6MA, hb_pkg::I_12MA5, 1'h1};
			1: return {hb_pkg::I_12MA5, hb_pkg::I_25MA, 1'h1};
			2: return {hb_pkg::I_25MA, hb_pkg::I_50MA, 1'h1};
			4: return {hb_pkg::I_150MA, hb_pkg::I_300MA, 1'h1};
			5: return {hb_pkg::I_25MA, hb_pkg::I_50MA, 1'h0};
			default: return {hb_pkg::I_100MA, hb_pkg::I_200MA, 1'h1};
		endcase
	endfunction : exp_set

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (30000) @(posedge clk);
		num_errors++;
		end_sim();
	end

	initial begin
		void'($urandom(32'h83b9fe57));
		cyc(3);
		for (int l = 0; l < 8; l++) begin
			nrst <= 0;
			drive_strength_select <= 3'(l);
			cyc(2);
			nrst <= 1;
			cyc(3);
			note("drive_setting", 1, exp_set(l));
			drive_strength_select <= 3'(7 - l);
			cyc(3);
			note("drive_setting held", 1, exp_set(l));
			cyc(1);
		end
		$display("test drive strength done");
		for (int c = 0; c < 4; c++) begin
			bridge_inputs <= 2'(c);
			cyc(80);
			note("gate_drive", 0, 25'(cmd_gate[c]));
		end
		bridge_inputs <= 2'h2;
		cyc(1 + $urandom_range(0, 3));
		bridge_inputs <= 2'h3;
		cyc(8);
		note("gate_drive glitch", 0, 25'h44);
		bridge_inputs <= 2'h2;
		for (k = 0; k < 20 && gate_drive[0].low_on !== 1'h0; k++) @(negedge clk);
		for (j = 0; j < 20 && gate_drive[0].high_on !== 1'h1; j++) @(negedge clk);
		note("gate_drive peak", 0, 25'h4b);
		put("input delay", 25'(k >= 5 && k <= 7), 25'h1);
		put("dead cycles", 25'(j), 25'h4);
		cyc(60);
		// The low gate's turn-off peak runs through the dead time into the high turn-on
		put("peak cycles", 25'(last[0]), 25'(hb_pkg::DEAD_CYC + hb_pkg::DRIVE_CYC));
		$display("test sequencing done");
		bridge_inputs <= 2'h3;
		// Raise the comparator only once brake has passed the deglitch
		cyc(8);
		force_chop <= 1;
		cyc(100);
		note("lines in brake", 2, 25'h3);
		force_chop <= 0;
		bridge_inputs <= 2'h2;
		for (k = 0; k < 400 && chop_line !== 1'h0; k++) @(negedge clk);
		cyc(60);
		note("lines chopping", 2, 25'h1);
		note("gate_drive chopping", 0, 25'h44);
		cyc(685);
		put("off cycles", 25'(last[1]), 25'h271);
		note("gate_drive restart", 0, 25'h48);
		bridge_inputs <= 2'h3;
		cyc(700);
		force_chop <= 1;
		bridge_inputs <= 2'h2;
		for (k = 0; k < 200 && gate_drive[0].high_on !== 1'h1; k++) @(negedge clk);
		for (j = 0; j < 200 && chop_line !== 1'h0; j++) @(negedge clk);
		// Blanking runs from the filtered command, so count from the input change
		put("blank cycles", 25'(k + j >= 50 && k + j <= 54), 25'h1);
		bridge_inputs <= 2'h3;
		current_limit_enable <= 0;
		cyc(700);
		bridge_inputs <= 2'h2;
		cyc(300);
		note("lines unregulated", 2, 25'h3);
		note("gate_drive unregulated", 0, 25'h48);
		force_chop <= 0;
		current_limit_enable <= 1;
		bridge_inputs <= 2'h3;
		cyc(80);
		$display("test chopping done");
		bridge_inputs <= 2'h2;
		cyc(40);
		trip_mask <= 4'h1;
		cyc($urandom_range(10, 45));
		trip_mask <= 4'h0;
		cyc(5);
		note("lines short trip", 2, 25'h3);
		trip_mask <= 4'h1;
		for (k = 0; k < 80 && fault_line !== 1'h0; k++) @(negedge clk);
		cyc(3);
		note("gate_drive tripped", 5, 25'h00);
		put("trip deglitch", 25'(k >= 49 && k <= 52), 25'h1);
		cyc(200);
		put("retry cycles", 25'(last[2]), 25'h14);
		trip_mask <= 4'h0;
		nrst <= 0;
		drive_strength_select <= 3'h5;
		cyc(2);
		nrst <= 1;
		cyc(40);
		trip_mask <= 4'h1;
		cyc(100);
		note("lines high side off", 2, 25'h3);
		trip_mask <= 4'h0;
		$display("test overcurrent done");
		for (int i = 0; i < 4; i++) begin
			sleep_n <= (i != 1);
			thermal_shutdown <= (i == 2);
			supply_undervoltage_lockout <= (i == 3);
			cyc(4);
			note("regulators", 3, {23'h0, 1'(i == 0), 1'(i != 1)});
			note("fault line", 2, {23'h0, 1'h1, 1'(i < 2)});
		end
		cyc(2);
		$display("test regulators done");
		end_sim();
	end
endmodule : testbench
